// ---- inc/adc_cfg_pkg.sv ----
// Purpose: Shared constants and types for the mode and clock config bank
// Assumes: 16-bit registers, 6-bit register addresses
// Notes:   Reserved bits are held at zero and read back as zero
package adc_cfg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          AW             = 6;
  localparam int          DW             = 16;
  localparam logic [5:0]  ADDR_OPCFG     = 6'h02;
  localparam logic [5:0]  ADDR_CLKCFG    = 6'h03;
  localparam logic [15:0] OPCFG_RESET    = 16'h0510;
  localparam logic [15:0] CLKCFG_RESET   = 16'h010E;
  localparam logic [15:0] OPCFG_MASK     = 16'h3F13;
  localparam logic [15:0] CLKCFG_MASK    = 16'h01FF;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int OP_REGCRC  = 13;
  localparam int OP_RXCRC   = 12;
  localparam int OP_CRCTYP  = 11;
  localparam int OP_RSTBIT  = 10;
  localparam int OP_WS_LO   = 8;
  localparam int OP_TMO     = 4;
  localparam int OP_FLOAT   = 1;
  localparam int OP_PULSE   = 0;
  localparam int CK_CHEN    = 8;
  localparam int CK_DIV_LO  = 6;
  localparam int CK_TURBO   = 5;
  localparam int CK_OSR_LO  = 2;
  localparam int CK_PWR_LO  = 0;

  // ****************************************************************
  // Encodings and figures
  // ****************************************************************
  localparam logic [15:0] POLY_CCITT    = 16'h1021;
  localparam logic [15:0] POLY_ANSI     = 16'h8005;
  localparam logic [15:0] CRC_SEED      = 16'hFFFF;
  localparam logic [14:0] OSR_BASE      = 15'h0080;
  localparam logic [14:0] OSR_TURBO     = 15'h0040;
  localparam logic [4:0]  WS_BITS16     = 5'h10;
  localparam logic [4:0]  WS_BITS24     = 5'h18;
  localparam logic [4:0]  WS_BITS32     = 5'h00;
  localparam int          CLK_MHZ       = 10;
  localparam int          PULSE_NS      = 400;
  localparam int          PULSE_CYC     = (PULSE_NS * CLK_MHZ) / 1000;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        channel_enable;
    logic [3:0]  divide_ratio;
    logic [14:0] oversample_ratio;
    logic [1:0]  power_select;
  } clock_cfg_t;

  typedef enum logic [1:0] {
    RDY_IDLE  = 2'b00,
    RDY_PULSE = 2'b01,
    RDY_HELD  = 2'b10
  } ready_state_t;

endpackage : adc_cfg_pkg

// ---- rtl/adc_mode_clock_config.sv ----
// Purpose: Operating-mode and clock configuration bank of the ADC core
// Assumes: Register requests come from the SPI command decoder, same clock
// Notes:   Ready pin open-drain style: enable low means driven
//
// How it works
// - Register-map CRC enable turns the continuous map check on, reset 0.
// - SPI input CRC enable turns frame CRC checking on, reset 0.
// - CRC type picks CCITT (0) or ANSI (1) for every CRC on both sides.
// - Writing 0 to the config reset bit clears the reset-occurred flag.
// - Word size 00=16, 01=24 (default), 10=32 zero pad, 11=32 sign ext.
// - Timeout enable turns the SPI frame timeout on, reset 1.
// - With no new data the ready pin is high, or floats if float bit is 1.
// - New data drive ready low and hold, or give a fixed low pulse.
// - Channel enable switches the single channel, reset enabled.
// - Divider field gives ratio 2, 4, 8 or 12, reset divide by 2.
// - Turbo forces oversampling 64 and ignores the ratio field.
// - Ratio field gives 128 shifted by the code, reset 011 for 1024.
// - Power 01 low power, 10 high resolution; host never writes 00/11.
// - Clock config sits at 03h and resets to 010Eh.
// - Operating config sits at 02h and resets to 0510h.
// - Reset flag is set by reset pin, power-on or reset command.
`timescale 1ns/100ps

module adc_mode_clock_config #(
  parameter int PULSE_CYCLES = adc_cfg_pkg::PULSE_CYC
) (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RESETN,
  // Register access from the command decoder
  input  wire adc_cfg_pkg::reg_req_t   REQ,
  output logic [adc_cfg_pkg::DW-1:0]   RDATA,
  output logic                         RVALID,
  // Device events
  input  wire logic                    RESET_CMD,
  input  wire logic                    DATA_AVAIL,
  input  wire logic                    DATA_TAKEN,
  // Mode controls
  output logic                         REG_CRC_ENABLE,
  output logic                         RX_CRC_ENABLE,
  output logic                         CRC_POLY_ANSI,
  output logic [15:0]                  CRC_POLY,
  output logic [1:0]                   WORD_SIZE_SELECT,
  output logic [4:0]                   WORD_BITS,
  output logic                         TIMEOUT_ENABLE,
  output logic                         RESET_FLAG,
  output logic                         REG_CRC_FAULT,
  // Clock controls
  output adc_cfg_pkg::clock_cfg_t      CLOCK_CFG,
  // Conversion ready pin
  output logic                         CONVERSION_READY_PIN_O,
  output logic                         CONVERSION_READY_PIN_OEN
);
  import adc_cfg_pkg::*;

  // ****************************************************************
  // Register bank
  // ****************************************************************
  logic [DW-1:0] opcfg_r;
  logic [DW-1:0] opcfg_nxt;
  logic [DW-1:0] clkcfg_r;
  logic [DW-1:0] clkcfg_nxt;
  logic          rst_flag_r;
  logic          rst_flag_nxt;
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rdata_nxt;
  logic          rvalid_r;
  logic          rvalid_nxt;
  logic          wr_op;
  logic          wr_clk;

  always_comb begin
    wr_op        = REQ.wr && (REQ.addr == ADDR_OPCFG);
    wr_clk       = REQ.wr && (REQ.addr == ADDR_CLKCFG);
    opcfg_nxt    = opcfg_r;
    clkcfg_nxt   = clkcfg_r;
    rdata_nxt    = rdata_r;
    rvalid_nxt   = REQ.rd;
    rst_flag_nxt = rst_flag_r;
    // Reserved bits are not stored, so they always read back zero
    if (wr_op) begin
      opcfg_nxt = REQ.wdata & OPCFG_MASK;
    end
    if (wr_clk) begin
      clkcfg_nxt = REQ.wdata & CLKCFG_MASK;
    end
    if (wr_op && !REQ.wdata[OP_RSTBIT]) begin
      rst_flag_nxt = 1'b0;
    end
    // A reset command in the same cycle as the clear wins
    if (RESET_CMD) begin
      rst_flag_nxt = 1'b1;
      opcfg_nxt    = OPCFG_RESET;
      clkcfg_nxt   = CLKCFG_RESET;
    end
    if (REQ.rd) begin
      unique case (REQ.addr)
        ADDR_OPCFG:  rdata_nxt = opcfg_r;
        ADDR_CLKCFG: rdata_nxt = clkcfg_r;
        default:     rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      opcfg_r    <= OPCFG_RESET;
      clkcfg_r   <= CLKCFG_RESET;
      rst_flag_r <= 1'b1;
      rdata_r    <= '0;
      rvalid_r   <= 1'b0;
    end else begin
      opcfg_r    <= opcfg_nxt;
      clkcfg_r   <= clkcfg_nxt;
      rst_flag_r <= rst_flag_nxt;
      rdata_r    <= rdata_nxt;
      rvalid_r   <= rvalid_nxt;
    end
  end

  // ****************************************************************
  // Decoded controls
  // ****************************************************************
  clock_cfg_t  clk_cfg_r;
  clock_cfg_t  clk_cfg_nxt;
  logic [4:0]  wbits_r;
  logic [4:0]  wbits_nxt;
  logic [15:0] poly_r;
  logic [15:0] poly_nxt;
  logic [2:0]  osr_code;

  always_comb begin
    osr_code = clkcfg_nxt[CK_OSR_LO +: 3];
    clk_cfg_nxt.channel_enable = clkcfg_nxt[CK_CHEN];
    clk_cfg_nxt.power_select   = clkcfg_nxt[CK_PWR_LO +: 2];
    unique case (clkcfg_nxt[CK_DIV_LO +: 2])
      2'b00:   clk_cfg_nxt.divide_ratio = 4'h2;
      2'b01:   clk_cfg_nxt.divide_ratio = 4'h4;
      2'b10:   clk_cfg_nxt.divide_ratio = 4'h8;
      default: clk_cfg_nxt.divide_ratio = 4'hC;
    endcase
    if (clkcfg_nxt[CK_TURBO]) begin
      clk_cfg_nxt.oversample_ratio = OSR_TURBO;
    end else begin
      clk_cfg_nxt.oversample_ratio = OSR_BASE << osr_code;
    end
    unique case (opcfg_nxt[OP_WS_LO +: 2])
      2'b00:   wbits_nxt = WS_BITS16;
      2'b01:   wbits_nxt = WS_BITS24;
      default: wbits_nxt = WS_BITS32;
    endcase
    poly_nxt = opcfg_nxt[OP_CRCTYP] ? POLY_ANSI : POLY_CCITT;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      clk_cfg_r.channel_enable   <= 1'b1;
      clk_cfg_r.divide_ratio     <= 4'h2;
      clk_cfg_r.oversample_ratio <= 15'h0400;
      clk_cfg_r.power_select     <= 2'b10;
      wbits_r                    <= WS_BITS24;
      poly_r                     <= POLY_CCITT;
    end else begin
      clk_cfg_r <= clk_cfg_nxt;
      wbits_r   <= wbits_nxt;
      poly_r    <= poly_nxt;
    end
  end

  // ****************************************************************
  // Register-map CRC check
  // ****************************************************************
  // Reference is taken on each legal change; the check then compares
  // the live map against it every cycle with no change, so a flipped bit shows up.
  function automatic logic [15:0] map_crc(input logic [31:0] data,
                                          input logic [15:0] poly);
    logic [15:0] c;
    c = CRC_SEED;
    for (int i = 31; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ poly;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction : map_crc

  logic [15:0] ref_crc_r;
  logic [15:0] ref_crc_nxt;
  logic        fault_r;
  logic        fault_nxt;
  logic        map_changed;

  always_comb begin
    map_changed = wr_op || wr_clk || RESET_CMD;
    ref_crc_nxt = ref_crc_r;
    fault_nxt   = fault_r;
    if (map_changed || !opcfg_r[OP_REGCRC]) begin
      ref_crc_nxt = map_crc({opcfg_nxt, clkcfg_nxt}, poly_nxt);
    end
    if (!opcfg_r[OP_REGCRC]) begin
      fault_nxt = 1'b0;
    end else if (!map_changed &&
                 map_crc({opcfg_r, clkcfg_r}, poly_r) != ref_crc_r) begin
      fault_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ref_crc_r <= '0;
      fault_r   <= 1'b0;
    end else begin
      ref_crc_r <= ref_crc_nxt;
      fault_r   <= fault_nxt;
    end
  end

  // ****************************************************************
  // Conversion ready pin
  // ****************************************************************
  ready_state_t rdy_st_r;
  ready_state_t rdy_st_nxt;
  logic [15:0]  pulse_cnt_r;
  logic [15:0]  pulse_cnt_nxt;
  logic         pin_o_r;
  logic         pin_o_nxt;
  logic         pin_oen_r;
  logic         pin_oen_nxt;

  always_comb begin
    rdy_st_nxt    = rdy_st_r;
    pulse_cnt_nxt = pulse_cnt_r;
    unique case (rdy_st_r)
      RDY_IDLE: begin
        if (DATA_AVAIL && opcfg_r[OP_PULSE]) begin
          rdy_st_nxt    = RDY_PULSE;
          pulse_cnt_nxt = 16'(PULSE_CYCLES - 1);
        end else if (DATA_AVAIL) begin
          rdy_st_nxt = RDY_HELD;
        end
      end
      RDY_PULSE: begin
        if (pulse_cnt_r == '0) begin
          rdy_st_nxt = RDY_IDLE;
        end else begin
          pulse_cnt_nxt = pulse_cnt_r - 16'h0001;
        end
      end
      RDY_HELD: begin
        // Held low until the sample is read out
        if (DATA_TAKEN) begin
          rdy_st_nxt = RDY_IDLE;
        end
      end
      default: rdy_st_nxt = RDY_IDLE;
    endcase
    if (rdy_st_nxt == RDY_IDLE) begin
      pin_o_nxt   = 1'b1;
      pin_oen_nxt = opcfg_nxt[OP_FLOAT];
    end else begin
      pin_o_nxt   = 1'b0;
      pin_oen_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdy_st_r    <= RDY_IDLE;
      pulse_cnt_r <= '0;
      pin_o_r     <= 1'b1;
      pin_oen_r   <= 1'b0;
    end else begin
      rdy_st_r    <= rdy_st_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      pin_o_r     <= pin_o_nxt;
      pin_oen_r   <= pin_oen_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign RDATA                    = rdata_r;
  assign RVALID                   = rvalid_r;
  assign REG_CRC_ENABLE           = opcfg_r[OP_REGCRC];
  assign RX_CRC_ENABLE            = opcfg_r[OP_RXCRC];
  assign CRC_POLY_ANSI            = opcfg_r[OP_CRCTYP];
  assign CRC_POLY                 = poly_r;
  assign WORD_SIZE_SELECT         = opcfg_r[OP_WS_LO +: 2];
  assign WORD_BITS                = wbits_r;
  assign TIMEOUT_ENABLE           = opcfg_r[OP_TMO];
  assign RESET_FLAG               = rst_flag_r;
  assign REG_CRC_FAULT            = fault_r;
  assign CLOCK_CFG                = clk_cfg_r;
  assign CONVERSION_READY_PIN_O   = pin_o_r;
  assign CONVERSION_READY_PIN_OEN = pin_oen_r;

endmodule : adc_mode_clock_config

// ---- testbench/adc_cfg_chk.sv ----
// Purpose: Port assertions for the mode and clock config bank
// Assumes: One clock domain
// Notes:   Pulse format bit is shadowed from writes to judge pulses
`timescale 1ns/100ps
module adc_cfg_chk #(
  parameter int PULSE_CYCLES = 4
) (
  // Clock and reset
  input wire logic                    CLK,
  input wire logic                    RESETN,
  // Requests and events
  input wire adc_cfg_pkg::reg_req_t   REQ,
  input wire logic [15:0]             RDATA,
  input wire logic                    RVALID,
  input wire logic                    RESET_CMD,
  input wire logic                    DATA_AVAIL,
  // Outputs watched
  input wire logic                    REG_CRC_ENABLE,
  input wire logic                    CRC_POLY_ANSI,
  input wire logic [15:0]             CRC_POLY,
  input wire logic [1:0]              WORD_SIZE_SELECT,
  input wire logic [4:0]              WORD_BITS,
  input wire logic                    RESET_FLAG,
  input wire logic                    REG_CRC_FAULT,
  input wire adc_cfg_pkg::clock_cfg_t CLOCK_CFG,
  input wire logic                    CONVERSION_READY_PIN_O,
  input wire logic                    CONVERSION_READY_PIN_OEN
);
  import adc_cfg_pkg::*;
  localparam int PC = PULSE_CYCLES;
  logic fmt_r;
  logic fmt_nxt;
  logic ck_wr;
  logic op_wr;
  assign ck_wr = REQ.wr && REQ.addr == ADDR_CLKCFG && !RESET_CMD;
  assign op_wr = REQ.wr && REQ.addr == ADDR_OPCFG && !RESET_CMD;
  always_comb begin
    fmt_nxt = fmt_r;
    if (RESET_CMD)
      fmt_nxt = 1'b0;
    else if (op_wr)
      fmt_nxt = REQ.wdata[OP_PULSE];
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN)
      fmt_r <= 1'b0;
    else
      fmt_r <= fmt_nxt;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // ********************
  // Assertions
  // ********************
  a_read_answer: assert property (
    REQ.rd && REQ.addr == ADDR_CLKCFG |=> RVALID && RDATA[15:9] == 7'h00)
    else $error("clock config read not answered");
  a_osr_decode: assert property (ck_wr |=>
    CLOCK_CFG.oversample_ratio == ($past(REQ.wdata[CK_TURBO]) ?
    OSR_TURBO : OSR_BASE << $past(REQ.wdata[4:2])))
    else $error("oversample ratio wrong");
  a_div_decode: assert property (ck_wr |=>
    CLOCK_CFG.divide_ratio == ($past(REQ.wdata[7:6]) == 2'b11 ? 4'hC :
    4'h2 << $past(REQ.wdata[7:6])))
    else $error("divide ratio wrong");
  a_chen_power: assert property (ck_wr |=>
    {CLOCK_CFG.channel_enable, CLOCK_CFG.power_select} ==
    $past({REQ.wdata[CK_CHEN], REQ.wdata[1:0]}))
    else $error("channel or power wrong");
  a_poly_select: assert property (op_wr |=>
    CRC_POLY_ANSI == $past(REQ.wdata[OP_CRCTYP]) &&
    CRC_POLY == ($past(REQ.wdata[OP_CRCTYP]) ? POLY_ANSI : POLY_CCITT))
    else $error("crc polynomial wrong");
  a_word_bits: assert property (op_wr |=>
    WORD_SIZE_SELECT == $past(REQ.wdata[9:8]) && WORD_BITS ==
    ($past(REQ.wdata[9:8]) == 2'b00 ? WS_BITS16 :
     $past(REQ.wdata[9:8]) == 2'b01 ? WS_BITS24 : WS_BITS32))
    else $error("word size wrong");
  a_flag_clear: assert property (
    op_wr && !REQ.wdata[OP_RSTBIT] |=> !RESET_FLAG)
    else $error("reset flag not cleared");
  a_flag_set: assert property (RESET_CMD |=> RESET_FLAG)
    else $error("reset flag not set");
  a_ready_low: assert property (DATA_AVAIL &&
    CONVERSION_READY_PIN_O |=> !CONVERSION_READY_PIN_O)
    else $error("ready pin not low on new data");
  a_pulse_len: assert property (
    $fell(CONVERSION_READY_PIN_O) && fmt_r |-> ##[PC:PC]
    CONVERSION_READY_PIN_O)
    else $error("ready pulse length wrong");
  a_low_driven: assert property (
    !CONVERSION_READY_PIN_O |-> !CONVERSION_READY_PIN_OEN)
    else $error("ready low not driven");
  a_fault_off: assert property (
    !REG_CRC_ENABLE [*3] |-> !REG_CRC_FAULT)
    else $error("map fault while check off");
  c_pulse: cover property ($fell(CONVERSION_READY_PIN_O) && fmt_r);
  c_clear: cover property (op_wr && !REQ.wdata[OP_RSTBIT]);
  c_turbo: cover property (ck_wr && REQ.wdata[CK_TURBO]);
endmodule : adc_cfg_chk
bind adc_mode_clock_config adc_cfg_chk #(.PULSE_CYCLES(PULSE_CYCLES))
  adc_cfg_chk_i (
    .CLK                      (CLK),
    .RESETN                   (RESETN),
    .REQ                      (REQ),
    .RDATA                    (RDATA),
    .RVALID                   (RVALID),
    .RESET_CMD                (RESET_CMD),
    .DATA_AVAIL               (DATA_AVAIL),
    .REG_CRC_ENABLE           (REG_CRC_ENABLE),
    .CRC_POLY_ANSI            (CRC_POLY_ANSI),
    .CRC_POLY                 (CRC_POLY),
    .WORD_SIZE_SELECT         (WORD_SIZE_SELECT),
    .WORD_BITS                (WORD_BITS),
    .RESET_FLAG               (RESET_FLAG),
    .REG_CRC_FAULT            (REG_CRC_FAULT),
    .CLOCK_CFG                (CLOCK_CFG),
    .CONVERSION_READY_PIN_O   (CONVERSION_READY_PIN_O),
    .CONVERSION_READY_PIN_OEN (CONVERSION_READY_PIN_OEN)
  );

// ---- testbench/adc_host_model.sv ----
// Purpose: Host model driving the register request port
// Assumes: Requests change on the falling edge of CLK
// Notes:   Idle address and data show the inverse of the last request
`timescale 1ns/100ps
module adc_host_model (
  // Clock and answer
  input  wire logic                CLK,
  input  wire logic                RVALID,
  input  wire logic [15:0]         RDATA,
  // Request
  output adc_cfg_pkg::reg_req_t    REQ
);
  import adc_cfg_pkg::*;
  initial REQ = '0;
  // ********************
  // Bus cycle
  // ********************
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    @(negedge CLK);
    REQ = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge CLK);
    // A read with no answer yields unknown so it can never match
    q = (RVALID === 1'b1) ? RDATA : 16'hXXXX;
    REQ = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
endmodule : adc_host_model

// ---- testbench/adc_mode_clock_config_tb_top.sv ----
// Purpose: Self-checking bench for the mode and clock config bank
// Assumes: Inputs change on the falling edge of CLK
// Notes:   Pulse length left at its 4-cycle default
`timescale 1ns/100ps
module adc_mode_clock_config_tb_top;
  import adc_cfg_pkg::*;
  logic        CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic        RESET_CMD = 1'b0;
  logic        DATA_AVAIL = 1'b0;
  logic        DATA_TAKEN = 1'b0;
  reg_req_t    REQ;
  logic [15:0] RDATA, CRC_POLY;
  logic        RVALID, REG_CRC_ENABLE, RX_CRC_ENABLE, CRC_POLY_ANSI;
  logic        TIMEOUT_ENABLE, RESET_FLAG, REG_CRC_FAULT, pin_o, pin_oen;
  logic [1:0]  WORD_SIZE_SELECT;
  logic [4:0]  WORD_BITS;
  clock_cfg_t  CLOCK_CFG;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  adc_mode_clock_config adc_mode_clock_config_i (
    .CLK                      (CLK),
    .RESETN                   (RESETN),
    .REQ                      (REQ),
    .RDATA                    (RDATA),
    .RVALID                   (RVALID),
    .RESET_CMD                (RESET_CMD),
    .DATA_AVAIL               (DATA_AVAIL),
    .DATA_TAKEN               (DATA_TAKEN),
    .REG_CRC_ENABLE           (REG_CRC_ENABLE),
    .RX_CRC_ENABLE            (RX_CRC_ENABLE),
    .CRC_POLY_ANSI            (CRC_POLY_ANSI),
    .CRC_POLY                 (CRC_POLY),
    .WORD_SIZE_SELECT         (WORD_SIZE_SELECT),
    .WORD_BITS                (WORD_BITS),
    .TIMEOUT_ENABLE           (TIMEOUT_ENABLE),
    .RESET_FLAG               (RESET_FLAG),
    .REG_CRC_FAULT            (REG_CRC_FAULT),
    .CLOCK_CFG                (CLOCK_CFG),
    .CONVERSION_READY_PIN_O   (pin_o),
    .CONVERSION_READY_PIN_OEN (pin_oen)
  );
  adc_host_model adc_host_model_i (
    .CLK    (CLK),
    .RVALID (RVALID),
    .RDATA  (RDATA),
    .REQ    (REQ)
  );
  initial forever #50 CLK = ~CLK;
  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input string n, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask : chk
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] q;
    adc_host_model_i.xfer(1'b0, a, 16'h0000, q);
    chk("rdata", e, q);
  endtask : rd
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] q;
    adc_host_model_i.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic pulse(ref logic s);
    @(negedge CLK);
    s = 1'b1;
    @(negedge CLK);
    s = 1'b0;
  endtask : pulse
  task automatic summarize;
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // ********************
  // Scenarios
  // ********************
  task automatic t_reset;
    rd(ADDR_OPCFG, OPCFG_RESET);
    rd(ADDR_CLKCFG, CLKCFG_RESET);
    rd(6'h04, 16'h0000);
    chk("clk", {1'b1, 4'h2, 15'h0400, 2'b10}, CLOCK_CFG);
    chk("mode", {4'h3, 5'h18}, {REG_CRC_ENABLE, RX_CRC_ENABLE,
      TIMEOUT_ENABLE, RESET_FLAG, WORD_BITS});
    chk("pin", 2'b10, {pin_o, pin_oen});
  endtask : t_reset
  task automatic t_clock;
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      // Host keeps reserved bits at zero; readback must match the mask
      d = {7'h00, i[0], i[1:0], 1'b0, i[2:0], i[0] ? 2'b01 : 2'b10};
      wr(ADDR_CLKCFG, d);
      rd(ADDR_CLKCFG, d & CLKCFG_MASK);
      chk("div", i[1:0] == 2'b11 ? 4'hC : 4'h2 << i[1:0],
        CLOCK_CFG.divide_ratio);
      chk("osr", 15'h0080 << i[2:0], CLOCK_CFG.oversample_ratio);
      chk("chen", {i[0], i[0] ? 2'b01 : 2'b10},
        {CLOCK_CFG.channel_enable, CLOCK_CFG.power_select});
    end
    wr(ADDR_CLKCFG, 16'h0025);
    chk("turbo", {1'b0, 4'h2, 15'h0040, 2'b01}, CLOCK_CFG);
  endtask : t_clock
  task automatic t_mode;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {2'b00, i[0], ~i[0], i[1], 1'b0, i[1:0], 3'b000, i[0], 4'h0};
      wr(ADDR_OPCFG, d);
      rd(ADDR_OPCFG, d & OPCFG_MASK);
      chk("crc", {i[0], ~i[0], i[1], i[1] ? POLY_ANSI : POLY_CCITT},
        {REG_CRC_ENABLE, RX_CRC_ENABLE, CRC_POLY_ANSI, CRC_POLY});
      chk("word", {i[1:0], i[1] ? WS_BITS32 : i[0] ? WS_BITS24 :
        WS_BITS16}, {WORD_SIZE_SELECT, WORD_BITS});
      chk("tmo", {i[0], 2'b00},
        {TIMEOUT_ENABLE, RESET_FLAG, REG_CRC_FAULT});
    end
    pulse(RESET_CMD);
    chk("flag", 1'b1, RESET_FLAG);
    rd(ADDR_OPCFG, OPCFG_RESET);
    rd(ADDR_CLKCFG, CLKCFG_RESET);
  endtask : t_mode
  task automatic t_ready;
    wr(ADDR_OPCFG, 16'h0012);
    chk("float", 2'b11, {pin_o, pin_oen});
    wr(ADDR_OPCFG, 16'h0010);
    chk("high", 2'b10, {pin_o, pin_oen});
    pulse(DATA_AVAIL);
    repeat (3) begin
      chk("held", 2'b00, {pin_o, pin_oen});
      @(negedge CLK);
    end
    pulse(DATA_TAKEN);
    @(negedge CLK);
    chk("taken", 2'b10, {pin_o, pin_oen});
    wr(ADDR_OPCFG, 16'h0011);
    pulse(DATA_AVAIL);
    for (int k = 0; k < 5; k++) begin
      chk("pulse", k == 4, pin_o);
      @(negedge CLK);
    end
  endtask : t_ready
  // ********************
  // Run control
  // ********************
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(negedge CLK);
    RESETN = 1'b1;
    t_reset();
    t_clock();
    t_mode();
    t_ready();
    summarize();
  end
endmodule : adc_mode_clock_config_tb_top
